// ---- hprkc_map.svh ----
// How it works
// - Power line floats except while pulsing
// - Reset line floats except while pulsing
// - Sense low, confirm 0.25 s: power pulse
// - Sense high, cancel 4 s: power pulse
// - Held cancel extends pulse up to 5 s
// - Sense high, confirm 4 s: 1 s reset
// - Restart self after keypad reset pulse
// - Separate enables for the three functions
// - Blank display while host sense low
// - Sense pin needs mode 011, flag 0
// - Control pins need mode 010, flag 0
// - Pin command 34 with three data bytes
// - Five pins indexed 0 to 4
// - Packet carries type, length, data, CRC
// - Every packet acknowledged within 250 ms
`ifndef HPRKC_MAP_SVH
`define HPRKC_MAP_SVH

// ***************************************************************
// Register byte addresses
// ***************************************************************
`define HPRKC_CTRL_ADDR     12'h000
`define HPRKC_STATUS_ADDR   12'h004
`define HPRKC_PKT0_ADDR     12'h008
`define HPRKC_PKT1_ADDR     12'h00c
`define HPRKC_PINCFG_ADDR   12'h010

// ***************************************************************
// Reset values and field codes
// ***************************************************************
`define HPRKC_CTRL_RESET    32'h03e8_0000
`define HPRKC_MODE_SENSE    3'h3
`define HPRKC_MODE_HIZ      3'h2
`define HPRKC_PIN_CMD       8'h22
`define HPRKC_PIN_LEN       8'h03
`define HPRKC_NUM_PINS      5
`define HPRKC_PIN_SENSE     3'h1
`define HPRKC_PIN_POWER     3'h2
`define HPRKC_PIN_RESET     3'h3
`define HPRKC_PIN_MAX       8'h04
`define HPRKC_CRC_INIT      16'hffff
`define HPRKC_CRC_POLY      16'h8408

// ***************************************************************
// Timing: clock, tick and hold times
// ***************************************************************
`define HPRKC_CLK_HZ        200000000
`define HPRKC_TICK_US       1000
`define HPRKC_TICK_CYCLES   (`HPRKC_CLK_HZ / 1000000 * `HPRKC_TICK_US)
`define HPRKC_ON_HOLD_MS    250
`define HPRKC_OFF_HOLD_MS   4000
`define HPRKC_RST_HOLD_MS   4000
`define HPRKC_EXT_MS        5000
`define HPRKC_RST_PULSE_MS  1000
`define HPRKC_ACK_MS        250
`define HPRKC_MS2T(ms)      ((ms) * 1000 / `HPRKC_TICK_US)

`endif

// ---- hprkc_pkg.sv ----
package hprkc_pkg;

  // Control word layout
  typedef struct packed {
    logic [15:0] pulse_ms;    // Power pulse width in ms
    logic [8:0]  pad;         // Reads zero
    logic        sense_sel;   // 1: sense through pin 1
    logic        blank_en;    // Blank display when host off
    logic        rst_high;    // Reset asserts high
    logic        pwr_invert;  // Power pulse drives high
    logic        rst_en;      // Forced reset enable
    logic        off_en;      // Forced power-off enable
    logic        on_en;       // Power-on enable
  } hprkc_ctrl_t;

  // One pin's configuration
  typedef struct packed {
    logic       user;         // Claimed for user use
    logic [2:0] mode;         // pin_drive_mode
  } hprkc_pincfg_t;

  // Keypad sequencer states
  typedef enum logic [2:0] {
    HPRKC_IDLE,
    HPRKC_PWR_ON,
    HPRKC_PWR_OFF,
    HPRKC_PWR_EXT,
    HPRKC_RST,
    HPRKC_RESTART,
    HPRKC_WAIT_REL
  } hprkc_state_t;

endpackage : hprkc_pkg

// ---- hprkc_hold_timer.sv ----
`timescale 1ns/1ps
`include "hprkc_map.svh"

module hprkc_hold_timer
  import hprkc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        key,
  input  wire logic        tick,
  output logic [12:0]      held_ms
);

  // ***************************************************************
  // Continuous-press counter
  // ***************************************************************
  // Any release clears the count, so only an unbroken press matures
  always_ff @(posedge mclk)
  begin
    if (srst || !key)
    begin
      held_ms <= 13'h0000;
    end
    else if (tick && held_ms != 13'h1fff)
    begin
      // Saturate rather than wrap into a false short hold
      held_ms <= held_ms + 13'h0001;
    end
  end

endmodule : hprkc_hold_timer

// ---- hprkc_keypad_ctrl.sv ----
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "hprkc_map.svh"

module hprkc_keypad_ctrl
  import hprkc_pkg::*;
#(
  parameter int TICK_CYCLES = `HPRKC_TICK_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sense_pin,
  input  wire logic        gpio1_in,
  input  wire logic        enter_key,
  input  wire logic        cancel_key,
  output logic             pwr_out,
  output logic             pwr_oe_n,
  output logic             rst_out,
  output logic             rst_oe_n,
  output logic             display_blank,
  output logic             self_restart,
  output logic             pkt_ack
);

  // ***************************************************************
  // Time constants in ms ticks
  // ***************************************************************
  localparam logic [12:0] ON_HOLD   = 13'(`HPRKC_MS2T(`HPRKC_ON_HOLD_MS));
  localparam logic [12:0] OFF_HOLD  = 13'(`HPRKC_MS2T(`HPRKC_OFF_HOLD_MS));
  localparam logic [12:0] RST_HOLD  = 13'(`HPRKC_MS2T(`HPRKC_RST_HOLD_MS));
  localparam logic [15:0] EXT_T     = 16'(`HPRKC_MS2T(`HPRKC_EXT_MS));
  localparam logic [15:0] RST_T     = 16'(`HPRKC_MS2T(`HPRKC_RST_PULSE_MS));

  hprkc_ctrl_t   ctrl;                         // Control register
  hprkc_pincfg_t pincfg [`HPRKC_NUM_PINS];     // Pin setup table
  hprkc_state_t  state;                        // Sequencer state
  logic [31:0]   pkt0;                         // Type, len, d0, d1
  logic [31:0]   tick_cnt;                     // Tick divider
  logic          tick;                         // One-ms enable
  logic [15:0]   pcnt;                         // Pulse length count
  logic [1:0]    sense_sy, gpio1_sy;           // Synchronisers
  logic [1:0]    enter_sy, cancel_sy;          // Synchronisers
  logic          sense;                        // Host power level
  logic          enter_s, cancel_s;            // Clean key levels
  logic [12:0]   enter_ms, cancel_ms;          // Hold durations
  logic          pkt_ok, pkt_err;              // Sticky packet flags
  logic          setup, acc_wr;                // APB phases
  logic          go;                           // Packet submitted
  logic [15:0]   pkt_crc;                      // CRC over packet
  logic          cmd_good;                     // Packet accepted
  logic          sense_ok, pwr_ok, rst_ok;     // Pin roles valid
  logic          fire_on, fire_off, fire_rst;  // Keypad triggers

  // ***************************************************************
  // Input synchronisers and ms tick
  // ***************************************************************
  // Every pin crosses two flops before anything looks at it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sense_sy  <= 2'h0;
      gpio1_sy  <= 2'h0;
      enter_sy  <= 2'h0;
      cancel_sy <= 2'h0;
    end
    else
    begin
      sense_sy  <= {sense_sy[0], sense_pin};
      gpio1_sy  <= {gpio1_sy[0], gpio1_in};
      enter_sy  <= {enter_sy[0], enter_key};
      cancel_sy <= {cancel_sy[0], cancel_key};
    end
  end

  // Divider giving a one-cycle enable each millisecond
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end
    else if (tick_cnt == 32'(TICK_CYCLES - 1))
    begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  assign enter_s  = enter_sy[1];
  assign cancel_s = cancel_sy[1];

  // Pin roles only hold while the pin keeps its default setup
  assign sense_ok = pincfg[`HPRKC_PIN_SENSE].mode == `HPRKC_MODE_SENSE
                    && !pincfg[`HPRKC_PIN_SENSE].user;
  assign pwr_ok   = pincfg[`HPRKC_PIN_POWER].mode == `HPRKC_MODE_HIZ
                    && !pincfg[`HPRKC_PIN_POWER].user;
  assign rst_ok   = pincfg[`HPRKC_PIN_RESET].mode == `HPRKC_MODE_HIZ
                    && !pincfg[`HPRKC_PIN_RESET].user;

  // With sense_sel set, a misconfigured sense pin reads as host off
  assign sense = ctrl.sense_sel ? (gpio1_sy[1] && sense_ok)
                                : sense_sy[1];

  // ***************************************************************
  // Key hold timers
  // ***************************************************************
  hprkc_hold_timer u_enter_hold (
    .mclk    (mclk),
    .srst    (srst),
    .key     (enter_s),
    .tick    (tick),
    .held_ms (enter_ms)
  );

  hprkc_hold_timer u_cancel_hold (
    .mclk    (mclk),
    .srst    (srst),
    .key     (cancel_s),
    .tick    (tick),
    .held_ms (cancel_ms)
  );

  // Each function has its own enable and sense condition
  assign fire_on  = ctrl.on_en && !sense
                    && enter_ms >= ON_HOLD;
  assign fire_off = ctrl.off_en && sense
                    && cancel_ms >= OFF_HOLD;
  assign fire_rst = ctrl.rst_en && sense
                    && enter_ms >= RST_HOLD;

  // ***************************************************************
  // Keypad sequencer
  // ***************************************************************
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state <= HPRKC_IDLE;
      pcnt  <= 16'h0000;
    end
    else
    begin
      unique case (state)
        HPRKC_IDLE:
        begin
          pcnt <= 16'h0000;
          // Reset wins over power-off if both keys mature together
          if (fire_rst)
          begin
            state <= HPRKC_RST;
          end
          else if (fire_off)
          begin
            state <= HPRKC_PWR_OFF;
          end
          else if (fire_on)
          begin
            state <= HPRKC_PWR_ON;
          end
        end
        HPRKC_PWR_ON:
        begin
          // Fixed pulse of the configured width
          if (pcnt >= ctrl.pulse_ms)
          begin
            state <= HPRKC_WAIT_REL;
          end
          else if (tick)
          begin
            pcnt <= pcnt + 16'h0001;
          end
        end
        HPRKC_PWR_OFF:
        begin
          // Minimum width, then extend while cancel is held
          if (pcnt >= ctrl.pulse_ms)
          begin
            pcnt  <= 16'h0000;
            state <= cancel_s ? HPRKC_PWR_EXT
                              : HPRKC_WAIT_REL;
          end
          else if (tick)
          begin
            pcnt <= pcnt + 16'h0001;
          end
        end
        HPRKC_PWR_EXT:
        begin
          if (!cancel_s || pcnt >= EXT_T)
          begin
            state <= HPRKC_WAIT_REL;
          end
          else if (tick)
          begin
            pcnt <= pcnt + 16'h0001;
          end
        end
        HPRKC_RST:
        begin
          if (pcnt >= RST_T)
          begin
            state <= HPRKC_RESTART;
          end
          else if (tick)
          begin
            pcnt <= pcnt + 16'h0001;
          end
        end
        HPRKC_RESTART:
        begin
          state <= HPRKC_WAIT_REL;
        end
        HPRKC_WAIT_REL:
        begin
          // Keys must come up before a new action can arm
          pcnt <= 16'h0000;
          if (!enter_s && !cancel_s)
          begin
            state <= HPRKC_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // Pin and display outputs
  // ***************************************************************
  // Drivers are enabled only inside a pulse; otherwise high-Z
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pwr_oe_n      <= 1'b1;
      pwr_out       <= 1'b0;
      rst_oe_n      <= 1'b1;
      rst_out       <= 1'b0;
      display_blank <= 1'b0;
      self_restart  <= 1'b0;
    end
    else
    begin
      pwr_oe_n <= !(pwr_ok && (state == HPRKC_PWR_ON
                  || state == HPRKC_PWR_OFF
                  || state == HPRKC_PWR_EXT));
      pwr_out  <= ctrl.pwr_invert;
      rst_oe_n <= !(rst_ok && state == HPRKC_RST);
      rst_out  <= ctrl.rst_high;
      display_blank <= ctrl.blank_en && !sense;
      self_restart  <= state == HPRKC_RESTART;
    end
  end

  // ***************************************************************
  // Packet CRC
  // ***************************************************************
  // Reflected CRC-16 over type, length and the three data bytes
  function automatic logic [15:0] hprkc_crc(input logic [39:0] bytes);
    logic [15:0] c;
    c = `HPRKC_CRC_INIT;
    for (int i = 0; i < 40; i++)
    begin
      if (c[0] ^ bytes[i])
      begin
        c = (c >> 1) ^ `HPRKC_CRC_POLY;
      end
      else
      begin
        c = c >> 1;
      end
    end
    return ~c;
  endfunction : hprkc_crc

  assign pkt_crc  = hprkc_crc({pwdata[7:0], pkt0});
  assign cmd_good = pkt_crc == pwdata[23:8]
                    && pkt0[7:0] == `HPRKC_PIN_CMD
                    && pkt0[15:8] == `HPRKC_PIN_LEN
                    && pkt0[23:16] <= `HPRKC_PIN_MAX;

  // ***************************************************************
  // APB slave
  // ***************************************************************
  assign setup  = psel && !penable;
  assign acc_wr = psel && penable && pwrite && pready;
  assign go     = acc_wr && paddr == `HPRKC_PKT1_ADDR;

  // Zero wait states; pready rises for the access phase
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup && !(paddr == `HPRKC_CTRL_ADDR
                 || paddr == `HPRKC_STATUS_ADDR
                 || paddr == `HPRKC_PKT0_ADDR
                 || paddr == `HPRKC_PKT1_ADDR
                 || paddr == `HPRKC_PINCFG_ADDR);
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite)
      begin
        unique case (paddr)
          `HPRKC_CTRL_ADDR:   prdata <= ctrl;
          `HPRKC_STATUS_ADDR: prdata <= {21'h00000, state, pkt_err,
                              pkt_ok, display_blank, !rst_oe_n,
                              !pwr_oe_n, cancel_s, enter_s, sense};
          `HPRKC_PKT0_ADDR:   prdata <= pkt0;
          `HPRKC_PINCFG_ADDR: prdata <= {12'h000, pincfg[4], pincfg[3],
                              pincfg[2], pincfg[1], pincfg[0]};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control and packet staging registers
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ctrl <= `HPRKC_CTRL_RESET;
      pkt0 <= 32'h0000_0000;
    end
    else if (acc_wr && paddr == `HPRKC_CTRL_ADDR)
    begin
      ctrl     <= pwdata;
      ctrl.pad <= 9'h000;
    end
    else if (acc_wr && paddr == `HPRKC_PKT0_ADDR)
    begin
      pkt0 <= pwdata;
    end
  end

  // Pin table; defaults give pins 1 to 3 their host roles
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      for (int i = 0; i < `HPRKC_NUM_PINS; i++)
      begin
        pincfg[i] <= {1'b0, `HPRKC_MODE_HIZ};
      end
      pincfg[`HPRKC_PIN_SENSE] <= {1'b0, `HPRKC_MODE_SENSE};
    end
    else if (go && cmd_good)
    begin
      pincfg[pkt0[18:16]] <= {pkt0[31:24] != 8'h00,
                              pwdata[2:0]};
    end
  end

  // Sticky packet flags; a new event beats a write-one clear
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      pkt_ok  <= 1'b0;
      pkt_err <= 1'b0;
      pkt_ack <= 1'b0;
    end
    else
    begin
      pkt_ack <= go;
      if (go && cmd_good)
      begin
        pkt_ok <= 1'b1;
      end
      else if (acc_wr && paddr == `HPRKC_STATUS_ADDR && pwdata[8])
      begin
        pkt_ok <= 1'b0;
      end
      if (go && !cmd_good)
      begin
        pkt_err <= 1'b1;
      end
      else if (acc_wr && paddr == `HPRKC_STATUS_ADDR && pwdata[9])
      begin
        pkt_err <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  pwr_idle_float_a: assert property (@(posedge mclk)
    disable iff (srst)
    (!pwr_oe_n |-> $past(state) inside {HPRKC_PWR_ON, HPRKC_PWR_OFF,
     HPRKC_PWR_EXT}))
    else $error("power line driven outside a pulse");
  rst_level_a: assert property (@(posedge mclk)
    disable iff (srst)
    (!rst_oe_n |-> rst_out == $past(ctrl.rst_high)
     && $past(state) == HPRKC_RST))
    else $error("reset line wrong level or state");
  on_hold_a: assert property (@(posedge mclk)
    disable iff (srst)
    (state == HPRKC_IDLE && fire_on && !fire_rst && !fire_off
     |=> state == HPRKC_PWR_ON && $past(enter_ms) >= ON_HOLD))
    else $error("power-on not started after hold");
  off_min_a: assert property (@(posedge mclk)
    disable iff (srst)
    (state == HPRKC_PWR_OFF ##1 state != HPRKC_PWR_OFF
     |-> $past(pcnt) >= $past(ctrl.pulse_ms)))
    else $error("power-off pulse cut short");
  ext_limit_a: assert property (@(posedge mclk)
    disable iff (srst)
    (state == HPRKC_PWR_EXT |-> pcnt <= EXT_T))
    else $error("extension beyond five seconds");
  rst_len_a: assert property (@(posedge mclk)
    disable iff (srst)
    ($fell(state == HPRKC_RST) |-> state == HPRKC_RESTART
     && $past(pcnt) == RST_T))
    else $error("reset pulse wrong length");
  self_restart_a: assert property (@(posedge mclk)
    disable iff (srst)
    (state == HPRKC_RESTART |=> self_restart ##1 !self_restart))
    else $error("self restart not pulsed");
  off_enable_a: assert property (@(posedge mclk)
    disable iff (srst)
    (state == HPRKC_IDLE && !ctrl.off_en && !fire_rst && !fire_on
     |=> state == HPRKC_IDLE))
    else $error("disabled function started");
  display_blank_a: assert property (@(posedge mclk)
    disable iff (srst)
    (ctrl.blank_en && !sense |=> display_blank))
    else $error("display not blanked");
  pkt_ack_a: assert property (@(posedge mclk)
    disable iff (srst)
    (go |=> pkt_ack ##0 (pkt_ok || pkt_err)))
    else $error("packet not acknowledged");
  key_release_a: assert property (@(posedge mclk)
    disable iff (srst)
    (!enter_s ##1 !enter_s |-> enter_ms == 13'h0000))
    else $error("hold count survived release");

endmodule : hprkc_keypad_ctrl

// ---- hprkc_host_model.sv ----
`timescale 1ns/1ps

// *****
// Motherboard power and reset switch inputs
// *****
module hprkc_host_model
(
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic pwr_out,
  input  wire logic pwr_oe_n,
  input  wire logic rst_out,
  input  wire logic rst_oe_n,
  output logic      pwr_line,
  output logic      rst_line,
  output logic      host_on
);
  logic oe_q;  // Power enable, last cycle

  // Board pull-ups hold released lines high
  assign pwr_line = pwr_oe_n ? 1'b1 : pwr_out;
  assign rst_line = rst_oe_n ? 1'b1 : rst_out;

  // Supply flips state when a power switch press ends
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      host_on <= 1'b0;
      oe_q    <= 1'b1;
    end
    else
    begin
      oe_q <= pwr_oe_n;
      // Reset presses never toggle the supply
      if (pwr_oe_n && !oe_q)
        host_on <= ~host_on;
    end
  end
endmodule : hprkc_host_model

// ---- host_power_reset_keypad_control_tb.sv ----
`timescale 1ns/1ps

module host_power_reset_keypad_control_tb import hprkc_pkg::*;;
  // *****
  // Signals
  // *****
  localparam int T = 4;  // Cycles per tick, shortened
  logic        mclk, srst;             // Clock, reset
  logic        psel, penable, pwrite;  // APB control
  logic [11:0] paddr;                  // APB address
  logic [31:0] pwdata, prdata, rd;     // APB data
  logic        pready, pslverr, err;   // APB answer
  logic        enter_key, cancel_key;  // Keys
  logic        pwr_out, pwr_oe_n, rst_out, rst_oe_n;
  logic        display_blank, self_restart, pkt_ack;
  logic        pwr_line, rst_line, host_on;  // Board side
  logic        lv;                     // Line level while driven
  int          n_mismatch = 0;
  int          checked = 0;
  int          n_rst = 0;              // Restart pulses
  int          n_ack = 0;              // Ack pulses
  int          t0, len;                // Delay and width

  // Free-running 200 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  hprkc_keypad_ctrl #(.TICK_CYCLES(T)) DUT (.mclk, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sense_pin(host_on), .gpio1_in(host_on), .enter_key, .cancel_key,
    .pwr_out, .pwr_oe_n, .rst_out, .rst_oe_n, .display_blank,
    .self_restart, .pkt_ack);

  hprkc_host_model HOST (.mclk, .srst, .pwr_out, .pwr_oe_n, .rst_out,
    .rst_oe_n, .pwr_line, .rst_line, .host_on);

  // Pulses are one cycle wide, so count them
  always @(posedge mclk)
  begin
    if (self_restart === 1'b1)
      n_rst++;
    if (pkt_ack === 1'b1)
      n_ack++;
  end

  // *****
  // Tasks
  // *****
  task automatic final_report();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Reports the bound that a count crossed
  task automatic rng(input int v, input int lo, input int hi);
    chk(32'(v), (v < lo) ? 32'(lo) : (v > hi) ? 32'(hi) : 32'(v));
  endtask : rng

  // One APB transfer; waits for pready, bounded
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb

  // Cycles until a pin is driven, then how long
  task automatic watch(input logic r, input int lim);
    t0 = 0;
    len = 0;
    while (t0 < lim && (r ? rst_oe_n : pwr_oe_n) !== 1'b0)
    begin
      @(posedge mclk);
      t0++;
    end
    lv = r ? rst_line : pwr_line;
    while (len < lim && (r ? rst_oe_n : pwr_oe_n) === 1'b0)
    begin
      @(posedge mclk);
      len++;
    end
  endtask : watch

  // Reference CRC, bits taken LSB first
  function automatic logic [15:0] crc(input logic [39:0] b);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 40; i++)
      c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    return ~c;
  endfunction : crc

  // Pin setup command; flip spoils the CRC
  task automatic pkt(input logic [7:0] d0, input logic [7:0] d2,
                     input logic [15:0] flip);
    logic [15:0] c;
    c = crc({d2, 8'h00, d0, 8'h03, 8'h22}) ^ flip;
    apb(1'b1, 12'h008, {8'h00, d0, 8'h03, 8'h22});
    apb(1'b1, 12'h00c, {8'h00, c, d2});
  endtask : pkt

  // *****
  // Sequence
  // *****
  initial
  begin
    srst = 1'b1;
    {psel, penable, pwrite, enter_key, cancel_key} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    // Defaults, and an unmapped place
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h03e8_0000);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0002_2232);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(32'(display_blank), 32'h0);
    // Power-on disabled, blanking on
    apb(1'b1, 12'h000, 32'h0014_0026);
    repeat (3) @(posedge mclk);
    chk(32'(display_blank), 32'h1);
    enter_key <= 1'b1;
    watch(1'b0, 1200);
    chk(32'(t0), 32'd1200);
    enter_key <= 1'b0;
    // Let the matured hold clear before the enable lands
    repeat (4) @(posedge mclk);
    apb(1'b1, 12'h000, 32'h0014_0027);
    // Early release must drive nothing
    enter_key <= 1'b1;
    watch(1'b0, 800);
    chk(32'(t0), 32'd800);
    enter_key <= 1'b0;
    watch(1'b0, 200);
    chk(32'(t0), 32'd200);
    // Power-on, 20 tick pulse, drives low
    enter_key <= 1'b1;
    watch(1'b0, 2000);
    rng(t0, 996, 1012);
    rng(len, 76, 84);
    chk(32'(lv), 32'h0);
    enter_key <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(32'(display_blank), 32'h0);
    // Forced reset, then self restart
    enter_key <= 1'b1;
    watch(1'b1, 20000);
    rng(t0, 15996, 16012);
    rng(len, 3996, 4004);
    chk(32'(lv), 32'h0);
    enter_key <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(32'(n_rst), 32'd1);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0014_0027);
    // Forced off, inverted, key held throughout
    apb(1'b1, 12'h000, 32'h0014_002f);
    cancel_key <= 1'b1;
    watch(1'b0, 40000);
    rng(t0, 15996, 16012);
    rng(len, 20072, 20088);
    chk(32'(lv), 32'h1);
    cancel_key <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(32'(display_blank), 32'h1);
    // Spare pin 0 only; control pins kept default
    pkt(8'h00, 8'h01, 16'h0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0002_2231);
    chk(32'(n_ack), 32'd1);
    pkt(8'h00, 8'h02, 16'h0001);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'hc0, 32'hc0);
    chk(32'(n_ack), 32'd2);
    // Power pin misset: sequence runs, line stays free
    pkt(8'h02, 8'h03, 16'h0);
    enter_key <= 1'b1;
    watch(1'b0, 1400);
    chk(32'(t0), 32'd1400);
    enter_key <= 1'b0;
    pkt(8'h02, 8'h02, 16'h0);
    // Sense taken through pin 1, then pin 1 misset
    apb(1'b1, 12'h000, 32'h0014_0067);
    enter_key <= 1'b1;
    watch(1'b0, 2000);
    rng(t0, 996, 1012);
    enter_key <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(32'(display_blank), 32'h0);
    pkt(8'h01, 8'h02, 16'h0);
    repeat (6) @(posedge mclk);
    chk(32'(display_blank), 32'h1);
    final_report();
  end
endmodule : host_power_reset_keypad_control_tb
